// File: include/dor_pkg.sv
// constants for the decoder output and status register bank
package dor_pkg;
  localparam logic [7:0] DOR_ADDR_CLAMP_END_LO = 8'h14;
  localparam logic [7:0] DOR_ADDR_CLAMP_END_HI = 8'h15;
  localparam logic [7:0] DOR_ADDR_OUT_FMT = 8'h16;
  localparam logic [7:0] DOR_ADDR_RST_STATUS = 8'h17;
  localparam logic [7:0] DOR_RST_CLAMP_END_LO = 8'h52;
  localparam logic [1:0] DOR_RST_CLAMP_END_HI = 2'h0;
  localparam logic [7:0] DOR_RST_OUT_FMT = 8'h00;
  localparam logic [7:0] DOR_ZERO8 = 8'h00;
  // output format field positions
  localparam int DOR_FMT_SQUARE = 7;
  localparam int DOR_FMT_FIELD_HI = 6;
  localparam int DOR_FMT_FIELD_LO = 4;
  localparam int DOR_FMT_BURST8 = 3;
  localparam int DOR_FMT_DRIVE = 2;
  localparam int DOR_FMT_SITING = 1;
  localparam logic [7:0] DOR_FMT_WMASK = 8'hFE;
  // reset/status field positions
  localparam int DOR_ST_SWRST = 7;
  localparam int DOR_ST_BLACK = 6;
  localparam int DOR_ST_LOCK = 5;
  localparam int DOR_ST_STDERR = 4;
  // software reset self-clears after this many clocks
  localparam logic [2:0] DOR_SWRST_CYCLES = 3'h4;
  localparam int DOR_LINE_W = 10;
  // field capture selector encodings
  typedef enum logic [2:0] {
    DOR_CAP_NONE = 3'h0,
    DOR_CAP_EVERY4 = 3'h1,
    DOR_CAP_EVERY2 = 3'h2,
    DOR_CAP_ODD2 = 3'h3,
    DOR_CAP_EVEN2 = 3'h4,
    DOR_CAP_ODD = 3'h5,
    DOR_CAP_EVEN = 3'h6,
    DOR_CAP_ALL = 3'h7
  } dor_cap_t;
endpackage

// File: verilog/dor_field_gate.sv
// field capture decision from selector and field sequence
`timescale 1ns/1ns
module dor_field_gate
  import dor_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic sync_rst_in,
  input wire logic field_start_in,
  input wire logic field_odd_in,
  input wire dor_cap_t sel_in,
  output logic capture_out
);
  logic [1:0] field_cnt_reg; // counts field starts modulo four
  logic [1:0] field_cnt_next;
  logic capture_reg; // capture decision for the current field
  logic capture_next;

  // decide at every field start whether this field is output
  always_comb begin
    field_cnt_next = field_cnt_reg;
    capture_next = capture_reg;
    if (sync_rst_in) begin
      field_cnt_next = 2'h0;
      capture_next = 1'b0;
    end else if (field_start_in) begin
      field_cnt_next = field_cnt_reg + 2'h1;
      unique case (sel_in)
        DOR_CAP_NONE: capture_next = 1'b0;
        DOR_CAP_EVERY4: capture_next = (field_cnt_reg == 2'h0);
        DOR_CAP_EVERY2: capture_next = ~field_cnt_reg[0];
        // odd/even every second: counter advances on every field, use bit 1
        DOR_CAP_ODD2: capture_next = field_odd_in & ~field_cnt_reg[1];
        DOR_CAP_EVEN2: capture_next = ~field_odd_in & ~field_cnt_reg[1];
        DOR_CAP_ODD: capture_next = field_odd_in;
        DOR_CAP_EVEN: capture_next = ~field_odd_in;
        DOR_CAP_ALL: capture_next = 1'b1;
      endcase
    end
  end

  // register the field sequence state
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      field_cnt_reg <= 2'h0;
      capture_reg <= 1'b0;
    end else begin
      field_cnt_reg <= field_cnt_next;
      capture_reg <= capture_next;
    end
  end

  assign capture_out = capture_reg;

  chk_none_no_capture: assert property (@(posedge clk_in)
    disable iff (!rst_n_in)
    (field_start_in && sel_in == DOR_CAP_NONE) |=> !capture_out)
    else $error("capture set with selector none");
endmodule

// File: verilog/dor_regs.sv
// output format, clamp timing and status register bank
//
// Function
// - clamp end low byte at 0x14, reset 0x52
// - clamp end bits 9-8 at 0x15, reset 0
// - clamp end value ends clamp pulse per line
// - unused bits ignore writes, read zero
// - bit 7 selects square pixel rate
// - three-bit selector picks captured fields
// - bit 3 selects 8-bit burst mode
// - bit 2 enables video output drivers
// - bit 1 selects line-aligned chroma siting
// - soft reset bit resets all but bus
// - soft reset self-clears after four clocks
// - black screen blanks video on vsync loss
// - read-only line lock flag
// - read-only standard error flag
`timescale 1ns/1ns
module dor_regs
  import dor_pkg::*;
#(
  parameter logic [DOR_LINE_W-1:0] STD_THRESHOLD = 10'h00A
) (
  input wire logic CORE_CLK_IN,
  input wire logic RESETN_IN,
  // register port from the serial bus interface
  input wire logic REG_WR_IN,
  input wire logic [7:0] REG_ADDR_IN,
  input wire logic [7:0] REG_WDATA_IN,
  output logic [7:0] REG_RDATA_OUT,
  // line timing and sync status from the decoder
  input wire logic [DOR_LINE_W-1:0] LINE_POS_IN,
  input wire logic LINE_START_IN,
  input wire logic PLL_LOCK_IN,
  input wire logic FIELD_START_IN,
  input wire logic FIELD_ODD_IN,
  input wire logic [DOR_LINE_W-1:0] LINES_MEASURED_IN,
  input wire logic [DOR_LINE_W-1:0] LINES_EXPECTED_IN,
  input wire logic VSYNC_LOST_IN,
  input wire logic PIXEL_READY_IN,
  // controls toward the datapath
  output logic CLAMP_PULSE_OUT,
  output logic SQUARE_PIXEL_OUT,
  output logic [2:0] FIELD_CAPTURE_SELECT_OUT,
  output logic BURST8_MODE_OUT,
  output logic OUTPUT_DRIVE_ENABLE_OUT,
  output logic CHROMA_LINE_ALIGN_OUT,
  output logic FORCE_BLACK_OUT,
  output logic PIXEL_VALID_STROBE_OUT,
  output logic SOFT_RESET_OUT
);
  logic [7:0] end_lo_reg; // clamp end low byte
  logic [7:0] end_lo_next;
  logic [1:0] end_hi_reg; // clamp end bits 9-8
  logic [1:0] end_hi_next;
  logic [7:0] fmt_reg; // output format, bit 0 always zero
  logic [7:0] fmt_next;
  logic black_reg; // black screen enable
  logic black_next;
  logic lock_reg; // line lock status
  logic lock_next;
  logic stderr_reg; // standard mismatch status
  logic stderr_next;
  logic [2:0] swrst_cnt_reg; // software reset cycle counter
  logic [2:0] swrst_cnt_next;
  logic swrst_reg; // software reset active
  logic swrst_next;
  logic clamp_reg; // clamp pulse state
  logic clamp_next;
  logic [7:0] rdata_reg; // registered read data
  logic [7:0] rdata_next;
  logic force_black_reg;
  logic force_black_next;
  logic valid_reg;
  logic valid_next;
  logic capture; // current field selected for output
  logic [DOR_LINE_W-1:0] clamp_end; // combined end position
  logic [DOR_LINE_W-1:0] line_diff; // absolute line-count difference

  // address decode shared by write and read paths
  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    hit = (a == o);
  endfunction

  assign clamp_end = {end_hi_reg, end_lo_reg};
  assign line_diff = (LINES_MEASURED_IN > LINES_EXPECTED_IN) ?
    LINES_MEASURED_IN - LINES_EXPECTED_IN :
    LINES_EXPECTED_IN - LINES_MEASURED_IN;

  // software reset: counter keeps the pulse for exactly four clocks
  always_comb begin
    swrst_next = swrst_reg;
    swrst_cnt_next = swrst_cnt_reg;
    if (swrst_reg) begin
      swrst_cnt_next = swrst_cnt_reg + 3'h1;
      if (swrst_cnt_reg == DOR_SWRST_CYCLES - 3'h1) begin
        swrst_next = 1'b0;
        swrst_cnt_next = 3'h0;
      end
    end else if (REG_WR_IN && hit(REG_ADDR_IN, DOR_ADDR_RST_STATUS) &&
                 REG_WDATA_IN[DOR_ST_SWRST]) begin
      swrst_next = 1'b1;
      swrst_cnt_next = 3'h0;
    end
  end

  // the serial interface is not reset by swrst; only this bank is
  always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      swrst_reg <= 1'b0;
      swrst_cnt_reg <= 3'h0;
    end else begin
      swrst_reg <= swrst_next;
      swrst_cnt_reg <= swrst_cnt_next;
    end
  end

  // register writes; software reset returns all fields to reset values
  always_comb begin
    end_lo_next = end_lo_reg;
    end_hi_next = end_hi_reg;
    fmt_next = fmt_reg;
    black_next = black_reg;
    lock_next = PLL_LOCK_IN;
    // soft reset wins over set: a mismatch is sticky until reset
    stderr_next = stderr_reg | (LINE_START_IN && FIELD_START_IN &&
      line_diff > STD_THRESHOLD);
    if (swrst_reg) begin
      end_lo_next = DOR_RST_CLAMP_END_LO;
      end_hi_next = DOR_RST_CLAMP_END_HI;
      fmt_next = DOR_RST_OUT_FMT;
      black_next = 1'b0;
      lock_next = 1'b0;
      stderr_next = 1'b0;
    end else if (REG_WR_IN) begin
      if (hit(REG_ADDR_IN, DOR_ADDR_CLAMP_END_LO))
        end_lo_next = REG_WDATA_IN;
      if (hit(REG_ADDR_IN, DOR_ADDR_CLAMP_END_HI))
        end_hi_next = REG_WDATA_IN[1:0];
      if (hit(REG_ADDR_IN, DOR_ADDR_OUT_FMT))
        fmt_next = REG_WDATA_IN & DOR_FMT_WMASK;
      if (hit(REG_ADDR_IN, DOR_ADDR_RST_STATUS))
        black_next = REG_WDATA_IN[DOR_ST_BLACK];
    end
  end

  // register file flip-flops
  always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      end_lo_reg <= DOR_RST_CLAMP_END_LO;
      end_hi_reg <= DOR_RST_CLAMP_END_HI;
      fmt_reg <= DOR_RST_OUT_FMT;
      black_reg <= 1'b0;
      lock_reg <= 1'b0;
      stderr_reg <= 1'b0;
    end else begin
      end_lo_reg <= end_lo_next;
      end_hi_reg <= end_hi_next;
      fmt_reg <= fmt_next;
      black_reg <= black_next;
      lock_reg <= lock_next;
      stderr_reg <= stderr_next;
    end
  end

  // read mux; unmapped addresses and unused bits read zero
  always_comb begin
    rdata_next = DOR_ZERO8;
    if (hit(REG_ADDR_IN, DOR_ADDR_CLAMP_END_LO))
      rdata_next = end_lo_reg;
    else if (hit(REG_ADDR_IN, DOR_ADDR_CLAMP_END_HI))
      rdata_next = {6'h00, end_hi_reg};
    else if (hit(REG_ADDR_IN, DOR_ADDR_OUT_FMT))
      rdata_next = fmt_reg;
    else if (hit(REG_ADDR_IN, DOR_ADDR_RST_STATUS)) begin
      rdata_next[DOR_ST_SWRST] = swrst_reg;
      rdata_next[DOR_ST_BLACK] = black_reg;
      rdata_next[DOR_ST_LOCK] = lock_reg;
      rdata_next[DOR_ST_STDERR] = stderr_reg;
    end
  end

  // clamp pulse: rises at line start, falls at the programmed end
  always_comb begin
    clamp_next = clamp_reg;
    if (swrst_reg)
      clamp_next = 1'b0;
    else if (LINE_START_IN)
      clamp_next = 1'b1;
    else if (LINE_POS_IN == clamp_end)
      clamp_next = 1'b0;
  end

  // blanking and valid strobe; valid only when the field is captured
  always_comb begin
    force_black_next = black_reg & VSYNC_LOST_IN;
    // capture only moves at field starts and soft reset, so the selector is also
    // tested here: a switch to none stops the strobes at once
    valid_next = capture & PIXEL_READY_IN &
      fmt_reg[DOR_FMT_DRIVE] & ~swrst_reg &
      (fmt_reg[DOR_FMT_FIELD_HI:DOR_FMT_FIELD_LO] != DOR_CAP_NONE);
  end

  // output-side flip-flops and read data
  always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      clamp_reg <= 1'b0;
      rdata_reg <= DOR_ZERO8;
      force_black_reg <= 1'b0;
      valid_reg <= 1'b0;
    end else begin
      clamp_reg <= clamp_next;
      rdata_reg <= rdata_next;
      force_black_reg <= force_black_next;
      valid_reg <= valid_next;
    end
  end

  // field sequence tracking for the capture selector
  dor_field_gate u_gate (
    .clk_in(CORE_CLK_IN),
    .rst_n_in(RESETN_IN),
    .sync_rst_in(swrst_reg),
    .field_start_in(FIELD_START_IN),
    .field_odd_in(FIELD_ODD_IN),
    .sel_in(dor_cap_t'(fmt_reg[DOR_FMT_FIELD_HI:DOR_FMT_FIELD_LO])),
    .capture_out(capture)
  );

  assign REG_RDATA_OUT = rdata_reg;
  assign CLAMP_PULSE_OUT = clamp_reg;
  assign SQUARE_PIXEL_OUT = fmt_reg[DOR_FMT_SQUARE];
  assign FIELD_CAPTURE_SELECT_OUT =
    fmt_reg[DOR_FMT_FIELD_HI:DOR_FMT_FIELD_LO];
  assign BURST8_MODE_OUT = fmt_reg[DOR_FMT_BURST8];
  assign OUTPUT_DRIVE_ENABLE_OUT = fmt_reg[DOR_FMT_DRIVE];
  assign CHROMA_LINE_ALIGN_OUT = fmt_reg[DOR_FMT_SITING];
  assign FORCE_BLACK_OUT = force_black_reg;
  assign PIXEL_VALID_STROBE_OUT = valid_reg;
  assign SOFT_RESET_OUT = swrst_reg;

  chk_end_lo_write: assert property (@(posedge CORE_CLK_IN)
    disable iff (!RESETN_IN)
    (REG_WR_IN && REG_ADDR_IN == DOR_ADDR_CLAMP_END_LO && !swrst_reg)
    |=> end_lo_reg == $past(REG_WDATA_IN))
    else $error("clamp end low byte not stored");
  chk_end_hi_mask: assert property (@(posedge CORE_CLK_IN)
    disable iff (!RESETN_IN)
    (REG_WR_IN && REG_ADDR_IN == DOR_ADDR_CLAMP_END_HI && !swrst_reg)
    ##2 REG_ADDR_IN == DOR_ADDR_CLAMP_END_HI |->
    REG_RDATA_OUT[7:2] == 6'h00)
    else $error("clamp end high upper bits not zero");
  chk_clamp_falls: assert property (@(posedge CORE_CLK_IN)
    disable iff (!RESETN_IN)
    (!LINE_START_IN && !swrst_reg && LINE_POS_IN == clamp_end)
    |=> !CLAMP_PULSE_OUT)
    else $error("clamp pulse did not end");
  chk_fmt_bit0: assert property (@(posedge CORE_CLK_IN)
    disable iff (!RESETN_IN)
    fmt_reg[0] == 1'b0)
    else $error("unused format bit stored");
  chk_square_sel: assert property (@(posedge CORE_CLK_IN)
    disable iff (!RESETN_IN)
    (REG_WR_IN && REG_ADDR_IN == DOR_ADDR_OUT_FMT && !swrst_reg)
    |=> SQUARE_PIXEL_OUT == $past(REG_WDATA_IN[DOR_FMT_SQUARE]))
    else $error("square pixel select wrong");
  chk_drive_en: assert property (@(posedge CORE_CLK_IN)
    disable iff (!RESETN_IN)
    PIXEL_VALID_STROBE_OUT |-> $past(OUTPUT_DRIVE_ENABLE_OUT))
    else $error("valid while outputs disabled");
  chk_swrst_len: assert property (@(posedge CORE_CLK_IN)
    disable iff (!RESETN_IN)
    $rose(swrst_reg) |-> swrst_reg [*4] ##1 !swrst_reg)
    else $error("soft reset not four clocks");
  chk_swrst_clears: assert property (@(posedge CORE_CLK_IN)
    disable iff (!RESETN_IN)
    swrst_reg |=> end_lo_reg == DOR_RST_CLAMP_END_LO &&
    fmt_reg == DOR_RST_OUT_FMT)
    else $error("soft reset did not restore registers");
  chk_black_force: assert property (@(posedge CORE_CLK_IN)
    disable iff (!RESETN_IN)
    (black_reg && VSYNC_LOST_IN) |=> FORCE_BLACK_OUT)
    else $error("black screen not forced");
  chk_lock_clear: assert property (@(posedge CORE_CLK_IN)
    disable iff (!RESETN_IN)
    swrst_reg |=> !lock_reg && !stderr_reg)
    else $error("status not cleared by soft reset");
  chk_stderr_sticky: assert property (@(posedge CORE_CLK_IN)
    disable iff (!RESETN_IN)
    (stderr_reg && !swrst_reg) |=> stderr_reg)
    else $error("standard error flag dropped");
  chk_none_no_valid: assert property (@(posedge CORE_CLK_IN)
    disable iff (!RESETN_IN)
    (FIELD_CAPTURE_SELECT_OUT == DOR_CAP_NONE) |=> !PIXEL_VALID_STROBE_OUT)
    else $error("valid strobe with selector none");
  chk_burst_sel: assert property (@(posedge CORE_CLK_IN)
    disable iff (!RESETN_IN)
    (REG_WR_IN && REG_ADDR_IN == DOR_ADDR_OUT_FMT && !swrst_reg)
    |=> BURST8_MODE_OUT == $past(REG_WDATA_IN[DOR_FMT_BURST8]))
    else $error("burst mode select wrong");
  chk_siting_sel: assert property (@(posedge CORE_CLK_IN)
    disable iff (!RESETN_IN)
    (REG_WR_IN && REG_ADDR_IN == DOR_ADDR_OUT_FMT && !swrst_reg)
    |=> CHROMA_LINE_ALIGN_OUT == $past(REG_WDATA_IN[DOR_FMT_SITING]))
    else $error("chroma siting select wrong");
  chk_field_sel: assert property (@(posedge CORE_CLK_IN)
    disable iff (!RESETN_IN)
    (REG_WR_IN && REG_ADDR_IN == DOR_ADDR_OUT_FMT && !swrst_reg)
    |=> FIELD_CAPTURE_SELECT_OUT ==
    $past(REG_WDATA_IN[DOR_FMT_FIELD_HI:DOR_FMT_FIELD_LO]))
    else $error("field capture selector wrong");
endmodule

// File: bench/dor_host_model.sv
// host-side model that drives the register port of the bank
`timescale 1ns/1ns
module dor_host_model
  import dor_pkg::*;
(
  input wire logic clk_in,
  input wire logic [7:0] rdata_in,
  output logic wr_out,
  output logic [7:0] addr_out,
  output logic [7:0] wdata_out
);
  // idle port at time zero; parking on an unmapped address is harmless
  initial begin
    wr_out = 1'b0;
    addr_out = 8'hFF;
    wdata_out = 8'h00;
  end
  // one write: strobe raised at a falling edge, taken at the next rise
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    begin
      @(negedge clk_in);
      wr_out = 1'b1;
      addr_out = a;
      wdata_out = d;
      @(negedge clk_in);
      wr_out = 1'b0;
      wdata_out = ~d;  // stale data must not look valid
    end
  endtask
  // read data is registered, so two rising edges pass before sampling
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    begin
      @(negedge clk_in);
      addr_out = a;
      @(posedge clk_in);
      @(posedge clk_in);
      #1;
      d = rdata_in;
    end
  endtask
endmodule

// File: bench/dor_regs_tb_top.sv
// self-checking testbench for the output format and status registers
`timescale 1ns/1ns
module dor_regs_tb_top
  import dor_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic wr, line_start = 0, pll_lock = 0, field_start = 0, field_odd = 0;
  logic vsync_lost = 0, pix_ready = 0;
  logic [7:0] addr, wdata, rdata;
  logic [9:0] line_pos = 0, lines_meas = 0, lines_exp = 0;
  logic clamp, square, burst8, drive, align, black, pvalid, swrst;
  logic [2:0] fsel;
  int err_total = 0;
  int n_tests = 0;
  // 125 MHz core clock
  always #4 clk = ~clk;
  dor_host_model u_host (.clk_in(clk), .rdata_in(rdata), .wr_out(wr),
    .addr_out(addr), .wdata_out(wdata));
  dor_regs u_dut (.CORE_CLK_IN(clk), .RESETN_IN(rst_n), .REG_WR_IN(wr),
    .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata), .REG_RDATA_OUT(rdata),
    .LINE_POS_IN(line_pos), .LINE_START_IN(line_start),
    .PLL_LOCK_IN(pll_lock), .FIELD_START_IN(field_start),
    .FIELD_ODD_IN(field_odd), .LINES_MEASURED_IN(lines_meas),
    .LINES_EXPECTED_IN(lines_exp), .VSYNC_LOST_IN(vsync_lost),
    .PIXEL_READY_IN(pix_ready), .CLAMP_PULSE_OUT(clamp),
    .SQUARE_PIXEL_OUT(square), .FIELD_CAPTURE_SELECT_OUT(fsel),
    .BURST8_MODE_OUT(burst8), .OUTPUT_DRIVE_ENABLE_OUT(drive),
    .CHROMA_LINE_ALIGN_OUT(align), .FORCE_BLACK_OUT(black),
    .PIXEL_VALID_STROBE_OUT(pvalid), .SOFT_RESET_OUT(swrst));
  // single comparison point; case inequality so unknowns never match
  task automatic check(input string name, input logic [7:0] seen,
    input logic [7:0] exp);
    begin
      n_tests++;
      if (seen !== exp) begin
        err_total++;
        $display("Error %s expected %h seen %h", name, exp, seen);
      end
    end
  endtask
  // verdict and end of run
  task automatic wrap_up;
    begin
      if (err_total == 0 && n_tests > 0) begin
        $display("DONE - PASS");
      end else begin
        $display("DONE - FAIL");
      end
      $finish;
    end
  endtask
  // read one register and compare against an expected byte
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    begin
      u_host.rd_reg(a, d);
      check("reg_read", d, exp);
    end
  endtask
  // reset values, including an unmapped subaddress
  task automatic t_reset_values;
    begin
      rd_chk(DOR_ADDR_CLAMP_END_LO, 8'h52);
      rd_chk(DOR_ADDR_CLAMP_END_HI, 8'h00);
      rd_chk(DOR_ADDR_OUT_FMT, 8'h00);
      rd_chk(DOR_ADDR_RST_STATUS, 8'h00);
      rd_chk(8'h18, 8'h00);
    end
  endtask
  // all-ones writes, 0x4F to status: unused bits drop, every format field lands
  task automatic t_write_masks;
    begin
      u_host.wr_reg(DOR_ADDR_CLAMP_END_HI, 8'hFF);
      rd_chk(DOR_ADDR_CLAMP_END_HI, 8'h03);
      u_host.wr_reg(DOR_ADDR_OUT_FMT, 8'hFF);
      rd_chk(DOR_ADDR_OUT_FMT, 8'hFE);
      check("square", 8'(square), 8'h01);
      check("burst8", 8'(burst8), 8'h01);
      check("drive", 8'(drive), 8'h01);
      check("align", 8'(align), 8'h01);
      u_host.wr_reg(DOR_ADDR_RST_STATUS, 8'h4F);
      rd_chk(DOR_ADDR_RST_STATUS, 8'h40);
      u_host.wr_reg(8'h18, 8'hFF);
      rd_chk(8'h18, 8'h00);
    end
  endtask
  // black screen follows vsync loss only while enabled
  task automatic t_black;
    begin
      @(negedge clk) vsync_lost = 1'b1;
      @(negedge clk) check("black", 8'(black), 8'h01);
      u_host.wr_reg(DOR_ADDR_RST_STATUS, 8'h00);
      @(negedge clk) check("black", 8'(black), 8'h00);
      vsync_lost = 1'b0;
    end
  endtask
  // clamp pulse spans line start up to the programmed end position
  task automatic t_clamp;
    begin
      u_host.wr_reg(DOR_ADDR_CLAMP_END_LO, 8'h05);
      u_host.wr_reg(DOR_ADDR_CLAMP_END_HI, 8'h01);
      for (int p = 0; p < 'h108; p++) begin
        @(negedge clk);
        line_pos = 10'(p);
        line_start = (p == 0);
        @(posedge clk) #1;
        check("clamp", 8'(clamp), 8'(p < 'h105));
      end
      @(negedge clk) line_start = 1'b0;
    end
  endtask
  // one field start pulse of the given parity, then let valid settle
  task automatic fld_pulse(input logic odd);
    begin
      @(negedge clk);
      field_start = 1'b1;
      field_odd = odd;
      @(negedge clk) field_start = 1'b0;
      repeat (2) @(negedge clk);
    end
  endtask
  // four alternating fields under one selector; count captured fields
  task automatic fld_count(input logic [2:0] c, input logic [7:0] exp);
    int k;
    begin
      k = 0;
      u_host.wr_reg(DOR_ADDR_OUT_FMT, {1'b0, c, 4'h4});
      for (int i = 0; i < 4; i++) begin
        fld_pulse(i[0]);
        k += int'(pvalid);
      end
      check("captured", 8'(k), exp);
    end
  endtask
  // every selector code, then valid strobes against drive and none
  task automatic t_capture;
    begin
      pix_ready = 1'b1;
      for (int c = 0; c < 8; c++) begin
        u_host.wr_reg(DOR_ADDR_OUT_FMT, {1'b0, 3'(c), 4'h4});
        check("fsel", 8'(fsel), 8'(c));
      end
      @(negedge clk) field_start = 1'b1;
      @(negedge clk) field_start = 1'b0;
      repeat (3) @(negedge clk);
      check("valid", 8'(pvalid), 8'h01);
      u_host.wr_reg(DOR_ADDR_OUT_FMT, 8'h70);
      repeat (2) @(negedge clk);
      check("valid", 8'(pvalid), 8'h00);
      u_host.wr_reg(DOR_ADDR_OUT_FMT, 8'h04);
      repeat (3) @(negedge clk);
      check("valid", 8'(pvalid), 8'h00);
      fld_count(DOR_CAP_NONE, 8'h00);
      fld_count(DOR_CAP_EVERY4, 8'h01);
      fld_count(DOR_CAP_EVERY2, 8'h02);
      fld_count(DOR_CAP_ODD2, 8'h01);
      fld_count(DOR_CAP_EVEN2, 8'h01);
      fld_count(DOR_CAP_ODD, 8'h02);
      fld_count(DOR_CAP_EVEN, 8'h02);
      fld_count(DOR_CAP_ALL, 8'h04);
    end
  endtask
  // compare counts at a field start at line start
  task automatic cnt_pulse(input logic [9:0] m);
    begin
      @(negedge clk);
      lines_meas = m;
      lines_exp = 10'h0C8;
      line_start = 1'b1;
      field_start = 1'b1;
      @(negedge clk);
      line_start = 1'b0;
      field_start = 1'b0;
    end
  endtask
  // status flags, then soft reset with a write refused mid-way
  task automatic t_status_swrst;
    begin
      pll_lock = 1'b1;
      cnt_pulse(10'h0CB);
      rd_chk(DOR_ADDR_RST_STATUS, 8'h20);
      cnt_pulse(10'h064);
      rd_chk(DOR_ADDR_RST_STATUS, 8'h30);
      @(negedge clk) pll_lock = 1'b0;
      u_host.wr_reg(DOR_ADDR_RST_STATUS, 8'h80);
      check("swrst", 8'(swrst), 8'h01);
      u_host.wr_reg(DOR_ADDR_CLAMP_END_LO, 8'h11);
      @(posedge clk) #1 check("swrst", 8'(swrst), 8'h01);
      @(posedge clk) #1 check("swrst", 8'(swrst), 8'h00);
      rd_chk(DOR_ADDR_CLAMP_END_LO, 8'h52);
      rd_chk(DOR_ADDR_CLAMP_END_HI, 8'h00);
      rd_chk(DOR_ADDR_OUT_FMT, 8'h00);
      rd_chk(DOR_ADDR_RST_STATUS, 8'h00);
      check("drive", 8'(drive), 8'h00);
    end
  endtask
  // main sequence: hold reset 16 cycles, release off the rising edge
  initial begin
    repeat (16) @(posedge clk);
    @(negedge clk) rst_n = 1'b1;
    t_reset_values;
    t_write_masks;
    t_black;
    t_clamp;
    t_capture;
    t_status_swrst;
    wrap_up;
  end
  // watchdog: the sequence needs well under 1000 cycles
  initial begin
    #80000;
    err_total++;
    wrap_up;
  end
endmodule
